// ===== rtl/supervisor_watchdog_reset.sv
// reset supervisor: power-up, supply and watchdog reset, nv write timer, glitch filter
`timescale 1ns/1ns
// Summary of operation
// - period select 11 turns the watchdog fully off; factory default.
// - select 10 gives 250 ms, 01 gives 650 ms, 00 gives 1.5 s.
// - reset held 250 ms once triggered; host requests ignored meanwhile, supply low reloads the hold.
// - after power-up reset output held active 250 ms, then released.
// - self-timed nonvolatile write ends within 10 ms of its stop.
// - input pulses shorter than 50 ns are filtered out.
// - write enable latch cleared at power-up.
// - while reset active, serial traffic refused and aborted.
module supervisor_watchdog_reset #(
  parameter int unsigned WDOG_SHORT = supervisor_pkg::WDOG_SHORT_CYC,
  parameter int unsigned WDOG_MID = supervisor_pkg::WDOG_MID_CYC,
  parameter int unsigned WDOG_LONG = supervisor_pkg::WDOG_LONG_CYC,
  parameter int unsigned RESET_HOLD = supervisor_pkg::RESET_HOLD_CYC,
  parameter int unsigned NV_WRITE = supervisor_pkg::NV_WRITE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // host requests and supply sense
  input wire supervisor_pkg::host_req_t req_i,
  input wire supervisor_pkg::sense_t sense_i,
  // outputs
  output logic reset_o,
  output logic write_enable_latch_o,
  output logic nv_busy_o,
  output logic bus_abort_o,
  output logic trip_program_o
);
  // a zero count would leave the hold or write timer unable to start, or trip the watchdog at once, so refuse it at elaboration
  if (WDOG_SHORT == 0 || WDOG_MID == 0 || WDOG_LONG == 0) begin : g_bad_period
    $error("watchdog periods must be at least one cycle");
  end
  if (RESET_HOLD == 0) begin : g_bad_hold
    $error("reset hold must be at least one cycle");
  end
  if (NV_WRITE == 0) begin : g_bad_write
    $error("write time must be at least one cycle");
  end
  // the filter age counter is eight bits wide
  if (supervisor_pkg::GLITCH_CYC > 32'hff) begin : g_bad_filter
    $error("glitch filter too long for its age counter");
  end

  localparam int W = $bits(supervisor_pkg::host_req_t) + $bits(supervisor_pkg::sense_t);
  localparam logic [7:0] GCYC = 8'(supervisor_pkg::GLITCH_CYC);
  typedef logic [supervisor_pkg::CNT_W-1:0] cnt_t;

  // glitch filter: level accepted only after it stays stable GLITCH_CYC+2 samples
  logic [W-1:0] raw, stable_q, last_q;
  logic [W-1:0][7:0] age_q;
  assign raw = {req_i, sense_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_q <= '0;
    end else if (ce_i) begin
      last_q <= raw;
    end
  end

  // age saturates so a long steady level never wraps back to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      age_q <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < W; i++) begin
        if (raw[i] != last_q[i]) begin
          age_q[i] <= 8'h00;
        end else if (age_q[i] < GCYC) begin
          age_q[i] <= age_q[i] + 8'h01;
        end
      end
    end
  end

  // period select starts at off so a stray code cannot trip reset after power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_q <= {{($bits(supervisor_pkg::host_req_t)+1){1'b0}}, supervisor_pkg::SEL_OFF};
    end else if (ce_i) begin
      for (int i = 0; i < W; i++) begin
        if (raw[i] == last_q[i] && age_q[i] >= GCYC) begin
          stable_q[i] <= last_q[i];
        end
      end
    end
  end

  supervisor_pkg::host_req_t req_f;
  supervisor_pkg::sense_t sense_f;
  assign {req_f, sense_f} = stable_q;

  // edge detect so a held request acts once
  supervisor_pkg::host_req_t req_prev_q, req_rise;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_prev_q <= '0;
    end else if (ce_i) begin
      req_prev_q <= req_f;
    end
  end
  assign req_rise = req_f & ~req_prev_q;

  function automatic cnt_t period_of(input logic [1:0] sel);
    unique case (sel)
      supervisor_pkg::SEL_SHORT: period_of = cnt_t'(WDOG_SHORT);
      supervisor_pkg::SEL_MID: period_of = cnt_t'(WDOG_MID);
      supervisor_pkg::SEL_LONG: period_of = cnt_t'(WDOG_LONG);
      supervisor_pkg::SEL_OFF: period_of = '0;
    endcase
  endfunction

  // requests that alter nonvolatile state need the latch and a quiet reset
  function automatic logic gated(input logic in_reset, input logic latch, input logic rise);
    gated = !in_reset && latch && rise;
  endfunction

  // reset hold timer; rst_i stands for power-on
  cnt_t hold_q;
  logic wdog_expire;
  logic active;
  assign active = (hold_q != '0) || sense_f.supply_low;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= cnt_t'(RESET_HOLD);
    end else if (ce_i) begin
      if (sense_f.supply_low || wdog_expire) begin
        hold_q <= cnt_t'(RESET_HOLD);
      end else if (hold_q != '0) begin
        hold_q <= hold_q - cnt_t'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_o <= 1'b1;
    end else if (ce_i) begin
      reset_o <= active || wdog_expire;
    end
  end

  // watchdog
  cnt_t wdog_q;
  cnt_t wdog_period;
  logic wdog_armed;
  assign wdog_period = period_of(sense_f.wdog_period_sel);
  // select 11 keeps the count parked at zero rather than timing a zero period
  assign wdog_armed = !active && (sense_f.wdog_period_sel != supervisor_pkg::SEL_OFF);
  assign wdog_expire = wdog_armed && (wdog_q + cnt_t'(1) >= wdog_period);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog_q <= '0;
    end else if (ce_i) begin
      if (active || sense_f.wdog_period_sel == supervisor_pkg::SEL_OFF) begin
        wdog_q <= '0;
      end else if (req_rise.wdog_restart || wdog_expire) begin
        wdog_q <= '0;
      end else begin
        wdog_q <= wdog_q + cnt_t'(1);
      end
    end
  end

  // write enable latch; requests ignored while reset active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (ce_i && !active) begin
      if (req_rise.set_write_enable) begin
        write_enable_latch_o <= 1'b1;
      end else if (req_rise.clear_write_enable) begin
        write_enable_latch_o <= 1'b0;
      end
    end
  end

  // trip threshold program pulse, gated by latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_program_o <= 1'b0;
    end else if (ce_i) begin
      trip_program_o <= gated(active, write_enable_latch_o, req_rise.trip_program);
    end
  end

  // nonvolatile write timer, typical time keeps well inside the maximum
  cnt_t nv_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_q <= '0;
    end else if (ce_i) begin
      if (nv_q != '0) begin
        nv_q <= nv_q - cnt_t'(1);
      end else if (gated(active, write_enable_latch_o, req_rise.start_nv_write)) begin
        nv_q <= cnt_t'(NV_WRITE);
      end
    end
  end

  // busy rises with the load and falls as the count leaves one, NV_WRITE cycles in all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_busy_o <= 1'b0;
    end else if (ce_i) begin
      nv_busy_o <= (nv_q > cnt_t'(1)) || ((nv_q == '0)
                   && gated(active, write_enable_latch_o, req_rise.start_nv_write));
    end
  end

  // serial traffic is refused for exactly as long as reset is shown
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_abort_o <= 1'b1;
    end else if (ce_i) begin
      bus_abort_o <= active || wdog_expire;
    end
  end
endmodule

// ===== shared/supervisor_pkg.sv
// constants and carrier types for the reset supervisor
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;
  // times as printed, typical values used for counted delays
  localparam int unsigned WDOG_SHORT_MS = 250;
  localparam int unsigned WDOG_MID_MS = 650;
  localparam int unsigned WDOG_LONG_MS = 1500;
  localparam int unsigned RESET_HOLD_MS = 250;
  localparam int unsigned NV_WRITE_TYP_MS = 5;
  localparam int unsigned NV_WRITE_MAX_MS = 10;
  localparam int unsigned GLITCH_NS = 50;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WDOG_SHORT_CYC = WDOG_SHORT_MS * CYC_PER_MS;
  localparam int unsigned WDOG_MID_CYC = WDOG_MID_MS * CYC_PER_MS;
  localparam int unsigned WDOG_LONG_CYC = WDOG_LONG_MS * CYC_PER_MS;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CYC_PER_MS;
  localparam int unsigned NV_WRITE_CYC = NV_WRITE_TYP_MS * CYC_PER_MS;
  // least time rounds up
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W = 32;
  localparam logic [1:0] SEL_LONG = 2'h0;
  localparam logic [1:0] SEL_MID = 2'h1;
  localparam logic [1:0] SEL_SHORT = 2'h2;
  localparam logic [1:0] SEL_OFF = 2'h3;

  typedef struct packed {
    logic wdog_restart;
    logic start_nv_write;
    logic set_write_enable;
    logic clear_write_enable;
    logic trip_program;
  } host_req_t;

  typedef struct packed {
    logic supply_low;
    logic [1:0] wdog_period_sel;
  } sense_t;
endpackage

// ===== verification/host_model.sv
// host side: services the watchdog
`timescale 1ns/1ns
module host_model #(parameter int unsigned KICK = 24) (
  // ports
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic reset_i,
  output logic restart_o = 1'b0
);
  int n = 0;
  // 8-cycle level so the input filter passes it
  always @(posedge clk_i) begin
    n = (en_i && !reset_i) ? (n + 1) % KICK : 0;
    restart_o <= n >= KICK - 8;
  end
endmodule

// ===== verification/supervisor_watchdog_reset_chk.sv
// port assertions for the reset supervisor
`timescale 1ns/1ns
module supervisor_watchdog_reset_chk #(parameter int unsigned RESET_HOLD = 20, NV_WRITE = 10) (
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire supervisor_pkg::sense_t sense_i,
  input wire logic reset_o,
  input wire logic write_enable_latch_o,
  input wire logic nv_busy_o,
  input wire logic bus_abort_o,
  input wire logic trip_program_o
);
  // run lengths, cleared by reset so no unknown reaches a compare
  logic [31:0] hi_q;
  logic [31:0] bz_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hi_q <= '0;
    end else begin
      hi_q <= reset_o ? hi_q + 32'h1 : '0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bz_q <= '0;
    end else begin
      bz_q <= nv_busy_o ? bz_q + 32'h1 : '0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_latch_cleared: assert property ($fell(rst_i) |-> !write_enable_latch_o)
    else $error("latch set");
  chk_powerup_hold: assert property ($fell(rst_i) |-> reset_o)
    else $error("no reset");
  chk_abort_in_reset: assert property (reset_o |-> bus_abort_o)
    else $error("no abort");
  chk_hold_length: assert property ($fell(reset_o) |-> $past(hi_q) >= RESET_HOLD)
    else $error("short hold");
  chk_trip_pulse: assert property (trip_program_o |=> !trip_program_o)
    else $error("long pulse");
  chk_trip_needs_latch: assert property (trip_program_o |-> $past(write_enable_latch_o))
    else $error("trip no latch");
  chk_write_bound: assert property ($fell(nv_busy_o) |-> $past(bz_q) <= NV_WRITE)
    else $error("long write");
  chk_supply_reset: assert property (sense_i.supply_low [*6] |-> ##[0:3] reset_o)
    else $error("no supply reset");
endmodule
bind supervisor_watchdog_reset supervisor_watchdog_reset_chk #(
  .RESET_HOLD(RESET_HOLD), .NV_WRITE(NV_WRITE)) chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .sense_i(sense_i), .reset_o(reset_o), .write_enable_latch_o(write_enable_latch_o),
  .nv_busy_o(nv_busy_o), .bus_abort_o(bus_abort_o), .trip_program_o(trip_program_o));

// ===== verification/supervisor_watchdog_reset_tb.sv
// bench for the reset supervisor
`timescale 1ns/1ns
module supervisor_watchdog_reset_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic en = 0;
  logic ce = 1;
  logic kick;
  logic [3:0] rq = '0;
  logic low = 0;
  logic [1:0] sel = 2'h3;
  logic rs, write_enable_latch, bz, ab, tp;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int trips = 0;
  int bzc = 0;
  supervisor_pkg::host_req_t req;
  supervisor_pkg::sense_t sense;
  assign req = {kick, rq};
  assign sense = {low, sel};
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    trips += tp;
    bzc += bz;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  supervisor_watchdog_reset #(.WDOG_SHORT(40), .WDOG_MID(60), .WDOG_LONG(80), .RESET_HOLD(20),
    .NV_WRITE(10)) supervisor_watchdog_reset_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .req_i(req), .sense_i(sense), .reset_o(rs), .write_enable_latch_o(write_enable_latch), .nv_busy_o(bz),
    .bus_abort_o(ab), .trip_program_o(tp));
  host_model host_model_inst (.clk_i(clk_i), .en_i(en), .reset_i(rs), .restart_o(kick));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wait_rst(input logic v, output int n);
    n = 0;
    while (rs !== v && n < 300) begin
      tick(1);
      n++;
    end
  endtask
  // rq bits: 3 nv write, 2 set latch, 1 clear latch, 0 trip program
  task automatic pulse(input int b);
    rq[b] = 1;
    tick(8);
    rq[b] = 0;
    tick(30);
  endtask
  task automatic t_powerup();
    int n;
    wait_rst(0, n);
    chk(n inside {[20:30]}, 1);
    chk(write_enable_latch, 0);
    chk(ab, 0);
  endtask
  task automatic t_latch_nv();
    rq[2] = 1;
    tick(2);
    rq[2] = 0;
    tick(10);
    chk(write_enable_latch, 0);
    pulse(0);
    chk(trips, 0);
    pulse(2);
    pulse(0);
    chk(trips, 1);
    pulse(3);
    chk(bzc, 10);
    pulse(1);
    pulse(3);
    chk(bzc, 10);
  endtask
  task automatic t_supply();
    int n;
    pulse(2);
    low = 1;
    tick(10);
    chk(ab, 1);
    pulse(1);
    pulse(0);
    chk(write_enable_latch, 1);
    chk(trips, 1);
    low = 0;
    wait_rst(0, n);
    chk(n inside {[20:32]}, 1);
    chk(ab, 0);
  endtask
  // mid-run reset with the clock enable held low after release
  task automatic t_repower();
    int n;
    rst_i = 1;
    tick(3);
    rst_i = 0;
    ce = 0;
    tick(40);
    chk(rs, 1);
    chk(write_enable_latch, 0);
    ce = 1;
    wait_rst(0, n);
    chk(n inside {[20:30]}, 1);
  endtask
  task automatic t_wdog();
    int n;
    int p [3] = '{40, 60, 80};
    for (int i = 0; i < 3; i++) begin
      sel = 2'(2 - i);
      wait_rst(1, n);
      chk(n inside {[p[i]:p[i] + 12]}, 1);
      sel = 2'h3;
      wait_rst(0, n);
    end
    tick(200);
    chk(rs, 0);
    sel = 2'h2;
    en = 1;
    tick(300);
    chk(rs, 0);
    en = 0;
    wait_rst(1, n);
    chk(n inside {[10:60]}, 1);
  endtask
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    tick(3);
    rst_i = 0;
    t_powerup();
    t_latch_nv();
    t_supply();
    t_repower();
    t_wdog();
    complete_run();
  end
endmodule
